// file: rtl/betx_pkg.sv
// shared constants and carrier types for the block encoder and transcoder
package betx_pkg;

    // parallel-interface control characters
    localparam logic [7:0] CH_IDLE = 8'h07;
    localparam logic [7:0] CH_LPI = 8'h06;
    localparam logic [7:0] CH_START = 8'hFB;
    localparam logic [7:0] CH_TERM = 8'hFD;
    localparam logic [7:0] CH_ERROR = 8'hFE;
    localparam logic [7:0] CH_SEQ = 8'h9C;
    localparam logic [7:0] CH_SIG = 8'h5C;

    // 7-bit block control codes
    localparam logic [6:0] CC_IDLE = 7'h00;
    localparam logic [6:0] CC_LPI = 7'h06;
    localparam logic [6:0] CC_ERROR = 7'h1E;

    // block type values
    localparam logic [7:0] BT_CTRL = 8'h1E;
    localparam logic [7:0] BT_START = 8'h78;
    localparam logic [7:0] BT_OS = 8'h4B;
    localparam logic [7:0] BT_TERM [8] = '{8'h87, 8'h99, 8'hAA, 8'hB4,
                                           8'hCC, 8'hD2, 8'hE1, 8'hFF};

    // ordered-set codes carried in the 0x4B block
    localparam logic [3:0] OC_SEQ = 4'h0;
    localparam logic [3:0] OC_SIG = 4'hF;

    // sync header as vector bits [1:0]; bit 0 goes out first
    localparam logic [1:0] SYNC_DATA = 2'h2;
    localparam logic [1:0] SYNC_CTRL = 2'h1;

    // field positions inside a 66-bit block
    localparam int TYPE_LSB = 2;
    localparam int PAY_LSB = 10;
    localparam int OS_CODE_LSB = 34;
    localparam int OS_ZERO_LSB = 38;

    // widths and depths
    localparam int BLK_W = 66;
    localparam int XC_W = 257;
    localparam int FIFO_DEPTH = 8;
    localparam int RM_CNT_W = 4;

    // reset value and saturation limit of the rate-match counts
    localparam logic [RM_CNT_W-1:0] RM_CNT_RST = 4'h0;
    localparam logic [RM_CNT_W-1:0] RM_CNT_MAX = 4'hF;

    // one parallel transfer: 64 data bits and 8 control flags
    typedef struct packed {
        logic [7:0] ctl;
        logic [63:0] data;
    } betx_xfer_t;

    // transcoder group slot, one-hot
    typedef enum logic [3:0] {
        SLOT0 = 4'b0001,
        SLOT1 = 4'b0010,
        SLOT2 = 4'b0100,
        SLOT3 = 4'b1000
    } betx_slot_t;

endpackage

// file: rtl/betx_tx.sv
// transmit 64b/66b block encoder, rate-match deletion/insertion, 66-to-257 transcoder
`timescale 1ns/1ps
`default_nettype none

module betx_fifo #(
    parameter int WIDTH = 66,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic ready_q;
    logic valid_q;
    wire push = in_valid && ready_q;
    wire pop = valid_q && out_ready;

    assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign in_ready = ready_q;
    assign out_valid = valid_q;
    assign out_data = mem[rd_q];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            ready_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            count_q <= count_d;
            ready_q <= count_d != FULL;
            valid_q <= count_d != '0;
        end
    end
endmodule

module betx_tx (
    input wire logic clock,
    input wire logic sys_rst,
    input wire betx_pkg::betx_xfer_t tx_in,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic eee_enabled,
    input wire logic del_req,
    input wire logic ins_req,
    output logic [betx_pkg::XC_W-1:0] xcoded,
    output logic xcoded_valid,
    input wire logic xcoded_ready
);
    import betx_pkg::*;

    // lane classification
    logic [7:0] lane_data;
    logic [7:0] lane_cc;
    logic [7:0] lane_err;
    logic [7:0] lane_start;
    logic [7:0] lane_term;
    logic [7:0] lane_seq;
    logic [7:0] lane_sig;
    logic [7:0] lane_lpi;
    logic [6:0] lane_code [8];
    logic [7:0] term_ok;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_lane
            localparam logic [7:0] LO = 8'((9'h001 << gi) - 9'h001);
            localparam logic [7:0] HI = ~LO & ~(8'h01 << gi);
            wire [7:0] ch = tx_in.data[8*gi +: 8];
            wire ctl = tx_in.ctl[gi];
            wire is_idle = ctl && (ch == CH_IDLE);
            assign lane_lpi[gi] = ctl && (ch == CH_LPI);
            assign lane_data[gi] = !ctl;
            assign lane_err[gi] = ctl && (ch == CH_ERROR);
            assign lane_start[gi] = ctl && (ch == CH_START);
            assign lane_term[gi] = ctl && (ch == CH_TERM);
            assign lane_seq[gi] = ctl && (ch == CH_SEQ);
            assign lane_sig[gi] = ctl && (ch == CH_SIG);
            // lpi only counts as a codable character in eee mode
            assign lane_cc[gi] = is_idle || lane_err[gi] || (lane_lpi[gi] && eee_enabled);
            assign lane_code[gi] = is_idle ? CC_IDLE :
                                   (lane_lpi[gi] && eee_enabled) ? CC_LPI : CC_ERROR;
            assign term_ok[gi] = lane_term[gi] && ((lane_data | ~LO) == 8'hFF)
                                 && ((lane_cc | ~HI) == 8'hFF);
        end
    endgenerate

    // block kind decode
    wire all_data = &lane_data;
    wire all_cc = &lane_cc;
    // start or ordered set anywhere but lane 0 fails these and becomes an error block
    wire start_blk = lane_start[0] && (&lane_data[7:1]);
    wire os_blk = (lane_seq[0] || lane_sig[0]) && (&lane_data[7:1])
                  && (tx_in.data[63:32] == 32'h0);
    wire any_term = |term_ok;
    wire idle_only = all_cc && !(|lane_err);
    wire drop_ok = idle_only || (os_blk && lane_seq[0]);

    logic [2:0] term_pos;
    always_comb begin
        term_pos = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (term_ok[k]) begin
                term_pos = 3'(k);
            end
        end
    end

    // block assembly
    logic [BLK_W-1:0] enc_blk;
    always_comb begin
        enc_blk = '0;
        if (all_data) begin
            enc_blk = {tx_in.data, SYNC_DATA};
        end else begin
            enc_blk[1:0] = SYNC_CTRL;
            if (all_cc) begin
                enc_blk[TYPE_LSB +: 8] = BT_CTRL;
                for (int m = 0; m < 8; m++) begin
                    enc_blk[PAY_LSB + 7*m +: 7] = lane_code[m];
                end
            end else if (start_blk) begin
                enc_blk[TYPE_LSB +: 8] = BT_START;
                enc_blk[65:PAY_LSB] = tx_in.data[63:8];
            end else if (os_blk) begin
                enc_blk[TYPE_LSB +: 8] = BT_OS;
                enc_blk[PAY_LSB +: 24] = tx_in.data[31:8];
                enc_blk[OS_CODE_LSB +: 4] = lane_seq[0] ? OC_SEQ : OC_SIG;
            end else if (any_term) begin
                enc_blk[TYPE_LSB +: 8] = BT_TERM[term_pos];
                for (int m = 0; m < 8; m++) begin
                    if (m < int'(term_pos)) begin
                        enc_blk[PAY_LSB + 8*m +: 8] = tx_in.data[8*m +: 8];
                    end else if (m > int'(term_pos)) begin
                        enc_blk[PAY_LSB + 7*m +: 7] = lane_code[m];
                    end
                end
            end else begin
                // invalid transfer: whole block of error codes
                enc_blk[TYPE_LSB +: 8] = BT_CTRL;
                for (int m = 0; m < 8; m++) begin
                    enc_blk[PAY_LSB + 7*m +: 7] = CC_ERROR;
                end
            end
        end
    end

    // rate matching
    logic [RM_CNT_W-1:0] del_q;
    logic [RM_CNT_W-1:0] ins_q;
    logic fifo_in_ready;
    wire del_pend = del_q != RM_CNT_RST;
    wire ins_pend = ins_q != RM_CNT_RST;
    wire drop_now = tx_valid && del_pend && drop_ok;
    wire ins_now = !tx_valid && ins_pend;
    wire fifo_wr = (tx_valid && !drop_now) || ins_now;
    wire [BLK_W-1:0] idle_blk = {56'h0, BT_CTRL, SYNC_CTRL};
    wire [BLK_W-1:0] fifo_wdata = tx_valid ? enc_blk : idle_blk;
    wire dropped = drop_now && fifo_in_ready;
    wire inserted = ins_now && fifo_in_ready;
    // a new request in the cycle of a drop keeps the count; one that finds the count at RM_CNT_MAX is lost
    wire del_inc = del_req && (del_q != RM_CNT_MAX);
    wire ins_inc = ins_req && (ins_q != RM_CNT_MAX);
    wire [RM_CNT_W-1:0] del_d = del_q + RM_CNT_W'(del_inc) - RM_CNT_W'(dropped);
    wire [RM_CNT_W-1:0] ins_d = ins_q + RM_CNT_W'(ins_inc) - RM_CNT_W'(inserted);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            del_q <= RM_CNT_RST;
            ins_q <= RM_CNT_RST;
        end else begin
            del_q <= del_d;
            ins_q <= ins_d;
        end
    end

    assign tx_ready = fifo_in_ready;

    // block buffer
    logic fifo_valid;
    logic fifo_pop;
    logic [BLK_W-1:0] fifo_rdata;

    betx_fifo #(
        .WIDTH(BLK_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(fifo_wr),
        .in_ready(fifo_in_ready),
        .in_data(fifo_wdata),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_rdata)
    );

    // transcoder
    betx_slot_t slot_q;
    logic [BLK_W-1:0] grp_q [3];
    logic [XC_W-1:0] xc_q;
    logic xc_vld_q;

    wire last_slot = slot_q == SLOT3;
    assign fifo_pop = fifo_valid && (!last_slot || !xc_vld_q || xcoded_ready);
    wire group_done = fifo_pop && last_slot;

    wire [BLK_W-1:0] g0 = grp_q[0];
    wire [BLK_W-1:0] g1 = grp_q[1];
    wire [BLK_W-1:0] g2 = grp_q[2];
    wire [BLK_W-1:0] g3 = fifo_rdata;
    wire [255:0] pay = {g3[65:2], g2[65:2], g1[65:2], g0[65:2]};
    wire [3:0] hb0 = {g3[0], g2[0], g1[0], g0[0]};
    wire [3:0] hb1 = {g3[1], g2[1], g1[1], g0[1]};
    wire grp_data = (hb0 == 4'h0) && (hb1 == 4'hF);
    wire grp_bad = |(~(hb0 ^ hb1));
    wire [1:0] first_c = hb0[0] ? 2'd0 : hb0[1] ? 2'd1 : hb0[2] ? 2'd2 : 2'd3;

    // payloads less the second type nibble of block c
    function automatic logic [251:0] omit_nibble(input logic [255:0] p, input logic [1:0] c);
        logic [251:0] r;
        case (c)
            2'd0: r = {p[255:8], p[3:0]};
            2'd1: r = {p[255:72], p[67:0]};
            2'd2: r = {p[255:136], p[131:0]};
            default: r = {p[255:200], p[195:0]};
        endcase
        return r;
    endfunction

    wire [XC_W-1:0] xc_data = {pay, 1'b1};
    wire [XC_W-1:0] xc_ctrl = {omit_nibble(pay, first_c), hb1, 1'b0};
    wire [XC_W-1:0] xc_bad = {omit_nibble(pay, 2'd0), 4'hF, 1'b0};
    wire [XC_W-1:0] xc_next = grp_data ? xc_data : grp_bad ? xc_bad : xc_ctrl;

    always_ff @(posedge clock) begin
        if (fifo_pop && !last_slot) begin
            grp_q[0] <= (slot_q == SLOT0) ? fifo_rdata : grp_q[0];
            grp_q[1] <= (slot_q == SLOT1) ? fifo_rdata : grp_q[1];
            grp_q[2] <= (slot_q == SLOT2) ? fifo_rdata : grp_q[2];
        end
    end

    betx_slot_t slot_d;
    always_comb begin
        case (slot_q)
            SLOT0: slot_d = SLOT1;
            SLOT1: slot_d = SLOT2;
            SLOT2: slot_d = SLOT3;
            SLOT3: slot_d = SLOT0;
            default: slot_d = SLOT0;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            slot_q <= SLOT0;
            xc_q <= '0;
            xc_vld_q <= 1'b0;
        end else begin
            if (fifo_pop) begin
                slot_q <= slot_d;
            end
            if (group_done) begin
                xc_q <= xc_next;
                xc_vld_q <= 1'b1;
            end else if (xcoded_ready) begin
                xc_vld_q <= 1'b0;
            end
        end
    end

    assign xcoded = xc_q;
    assign xcoded_valid = xc_vld_q;

    // checks
    wire [7:0] wr_type = fifo_wdata[TYPE_LSB +: 8];

    hdr_legal_a: assert property (@(posedge clock) disable iff (sys_rst)
        fifo_wr |-> (fifo_wdata[1:0] == SYNC_DATA || fifo_wdata[1:0] == SYNC_CTRL))
        else $error("encoded block with illegal sync header");

    data_hdr_a: assert property (@(posedge clock) disable iff (sys_rst)
        (fifo_wr && tx_valid) |-> ((tx_in.ctl == 8'h00) == (fifo_wdata[1:0] == SYNC_DATA)))
        else $error("sync header disagrees with control flags");

    type_defined_a: assert property (@(posedge clock) disable iff (sys_rst)
        (fifo_wr && fifo_wdata[1:0] == SYNC_CTRL) |-> (wr_type == BT_CTRL
        || wr_type == BT_START || wr_type == BT_OS || wr_type inside {BT_TERM}))
        else $error("undefined block type sent");

    os_filler_a: assert property (@(posedge clock) disable iff (sys_rst)
        (fifo_wr && fifo_wdata[1:0] == SYNC_CTRL && wr_type == BT_OS)
        |-> (fifo_wdata[65:OS_ZERO_LSB] == 28'h0))
        else $error("ordered-set filler not zero");

    err_prop_a: assert property (@(posedge clock) disable iff (sys_rst)
        (fifo_wr && tx_valid && lane_err[0]) |->
        (wr_type == BT_CTRL && fifo_wdata[PAY_LSB +: 7] == CC_ERROR))
        else $error("error character in lane 0 not propagated");

    lpi_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        (fifo_wr && tx_valid && !eee_enabled && lane_lpi[0]) |->
        (fifo_wdata[PAY_LSB +: 7] != CC_LPI))
        else $error("lpi sent without eee");

    one_block_a: assert property (@(posedge clock) disable iff (sys_rst)
        (tx_valid && tx_ready && !drop_now) |-> fifo_wr ##1 fifo_valid)
        else $error("accepted transfer produced no block");

    del_count_a: assert property (@(posedge clock) disable iff (sys_rst)
        (dropped && !del_req) |=> (del_q == $past(del_q) - 4'h1))
        else $error("deletion count not consumed");

    group_strobe_a: assert property (@(posedge clock) disable iff (sys_rst)
        (fifo_pop && slot_q != SLOT3) |=> !$rose(xc_vld_q))
        else $error("strobe before four blocks collected");

    data_group_a: assert property (@(posedge clock) disable iff (sys_rst)
        (group_done && grp_data) |=> (xc_q[0] && xc_q[256:193] == $past(g3[65:2])))
        else $error("all-data group packed wrongly");

    bad_group_a: assert property (@(posedge clock) disable iff (sys_rst)
        (group_done && grp_bad) |=> (xc_q[4:0] == 5'h1E))
        else $error("bad-header group flags wrong");

    mixed_group_a: assert property (@(posedge clock) disable iff (sys_rst)
        (group_done && !grp_bad && !grp_data) |=> (!xc_q[0] && xc_q[4:1] == $past(hb1)))
        else $error("mixed group header bits wrong");

endmodule

`default_nettype wire

// file: bench/betx_client.sv
// upstream client model: queued eight-lane transfers held until accepted
`timescale 1ns/1ps
`default_nettype none

module betx_client (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tx_ready,
    output var betx_pkg::betx_xfer_t tx_in,
    output var logic tx_valid
);
    import betx_pkg::*;

    betx_xfer_t q[$];
    bit slow;
    bit rest;

    initial begin
        tx_in = '0;
        tx_valid = 1'b0;
        slow = 1'b0;
        rest = 1'b0;
    end

    // hold the transfer until the accepting edge; idle lines toggle
    always @(posedge clock) begin
        rest = 1'b0;
        if (!sys_rst && tx_valid && tx_ready) begin
            void'(q.pop_front());
            rest = slow;
        end
        #1;
        if (!sys_rst && !rest && q.size() > 0) begin
            tx_in = q[0];
            tx_valid = 1'b1;
        end else begin
            tx_in = ~tx_in;
            tx_valid = 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the transmit encoder and transcoder
`timescale 1ns/1ps
`default_nettype none

module tb;
    import betx_pkg::*;

    localparam logic [55:0] ERR = {8{7'h1E}};
    localparam logic [63:0] IDL = {8{8'h07}};
    logic clock;
    logic sys_rst;
    logic eee_enabled;
    logic del_req;
    logic ins_req;
    logic xcoded_ready;
    logic tx_valid;
    logic tx_ready;
    logic xcoded_valid;
    betx_xfer_t tx_in;
    logic [XC_W-1:0] xcoded;
    logic [XC_W-1:0] got[$];
    int error_cnt;
    int checks;

    betx_client cli (.clock(clock), .sys_rst(sys_rst), .tx_ready(tx_ready),
        .tx_in(tx_in), .tx_valid(tx_valid));

    betx_tx dut (.clock(clock), .sys_rst(sys_rst), .tx_in(tx_in), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .eee_enabled(eee_enabled), .del_req(del_req),
        .ins_req(ins_req), .xcoded(xcoded), .xcoded_valid(xcoded_valid),
        .xcoded_ready(xcoded_ready));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (!sys_rst && xcoded_valid === 1'b1 && xcoded_ready) got.push_back(xcoded);
    end

    function automatic logic [63:0] dv(input int k);
        return {8{8'(k)}} ^ 64'hA5C3_0F1E_9B27_6D48;
    endfunction

    // upper seven octets of a data word, lane 0 left for a control character
    function automatic logic [55:0] dhi(input int k);
        logic [63:0] v;
        v = dv(k);
        return v[63:8];
    endfunction

    function automatic logic [65:0] dblk(input int k);
        return {dv(k), 2'b10};
    endfunction

    function automatic logic [65:0] cblk(input logic [7:0] t, input logic [55:0] p);
        return {p, t, 2'b01};
    endfunction

    // expected 257-bit block from four 66-bit blocks
    function automatic logic [256:0] xc(input logic [65:0] b0, b1, b2, b3);
        logic [65:0] b[4];
        logic [255:0] p;
        logic [256:0] r;
        int c = -1;
        b = '{b0, b1, b2, b3};
        for (int j = 0; j < 4; j++) begin
            p[64*j+:64] = b[j][65:2];
            if (b[j][0] && c < 0) c = j;
        end
        if (c < 0) return {p, 1'b1};
        r[0] = 1'b0;
        for (int j = 0; j < 4; j++) r[j+1] = b[j][1];
        for (int i = 5; i <= 256; i++) r[i] = (i <= 64 * c + 8) ? p[i-5] : p[i-1];
        return r;
    endfunction

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %0b, seen %0b", nm, e, g);
        end
    endtask

    task automatic cmp_xc(input logic [256:0] e, input logic [256:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected xcoded: expected %h, seen %h", e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic put(input logic [7:0] c, input logic [63:0] d);
        cli.q.push_back('{ctl: c, data: d});
    endtask

    task automatic settle();
        int n = 0;
        while ((cli.q.size() != 0 || tx_valid) && n < 200) begin
            step(1);
            n++;
        end
        if (n >= 200) begin
            error_cnt++;
            $display("unexpected settle: client queue not drained within bound");
            end_sim();
        end else begin
            step(2);
        end
    endtask

    task automatic want4(input logic [65:0] b0, b1, b2, b3);
        int n = 0;
        while (got.size() == 0 && n < 300) begin
            step(1);
            n++;
        end
        if (got.size() == 0) begin
            error_cnt++;
            $display("unexpected xcoded: no block within bound");
            end_sim();
        end else begin
            cmp_xc(xc(b0, b1, b2, b3), got.pop_front());
        end
    endtask

    initial begin
        int n;
        sys_rst = 1'b1;
        eee_enabled = 1'b1;
        del_req = 1'b0;
        ins_req = 1'b0;
        xcoded_ready = 1'b1;
        error_cnt = 0;
        checks = 0;
        step(16);
        cmp_bit("tx_ready", 1'b0, tx_ready);
        sys_rst = 1'b0;
        cli.slow = 1'b1;
        for (int k = 0; k < 4; k++) put(8'h00, dv(k));
        want4(dblk(0), dblk(1), dblk(2), dblk(3));
        cli.slow = 1'b0;
        $display("test all_data done");
        put(8'hFF, IDL);
        put(8'h00, dv(4));
        put(8'h00, dv(5));
        put(8'h01, {dhi(6), 8'hFB});
        want4(cblk(8'h1E, '0), dblk(4), dblk(5), cblk(8'h78, dhi(6)));
        put(8'h00, dv(7));
        put(8'h01, {32'h0, 24'hABCDEF, 8'h9C});
        put(8'hFF, {IDL[63:8], 8'hFD});
        put(8'h00, dv(8));
        want4(dblk(7), cblk(8'h4B, {32'h0, 24'hABCDEF}), cblk(8'h87, '0), dblk(8));
        $display("test control done");
        settle();
        eee_enabled = 1'b0;
        put(8'hFF, {IDL[63:8], 8'h06});
        put(8'hFF, {IDL[63:32], 8'hFE, IDL[23:0]});
        put(8'hFF, {IDL[63:24], 8'h33, IDL[15:0]});
        put(8'h00, dv(9));
        want4(cblk(8'h1E, ERR), cblk(8'h1E, 56'(7'h1E) << 21), cblk(8'h1E, ERR), dblk(9));
        eee_enabled = 1'b1;
        put(8'hFF, {IDL[63:8], 8'h06});
        for (int k = 0; k < 3; k++) put(8'hFF, IDL);
        want4(cblk(8'h1E, 56'h06), cblk(8'h1E, '0), cblk(8'h1E, '0), cblk(8'h1E, '0));
        $display("test errors done");
        xcoded_ready = 1'b0;
        for (int k = 10; k < 26; k++) put(8'h00, dv(k));
        n = 0;
        while (tx_ready !== 1'b0 && n < 100) begin
            step(1);
            n++;
        end
        cmp_bit("tx_ready", 1'b0, tx_ready);
        cmp_bit("xcoded_valid", 1'b1, xcoded_valid);
        xcoded_ready = 1'b1;
        for (int g = 10; g < 26; g += 4) want4(dblk(g), dblk(g + 1), dblk(g + 2), dblk(g + 3));
        $display("test backpressure done");
        settle();
        del_req = 1'b1;
        step(1);
        del_req = 1'b0;
        put(8'h01, {32'h0, 24'h123456, 8'h9C});
        for (int k = 30; k < 34; k++) put(8'h00, dv(k));
        want4(dblk(30), dblk(31), dblk(32), dblk(33));
        settle();
        ins_req = 1'b1;
        step(1);
        ins_req = 1'b0;
        step(4);
        for (int k = 34; k < 37; k++) put(8'h00, dv(k));
        want4(cblk(8'h1E, '0), dblk(34), dblk(35), dblk(36));
        $display("test rate_match done");
        put(8'h00, dv(40));
        put(8'h00, dv(41));
        settle();
        sys_rst = 1'b1;
        step(2);
        cmp_bit("tx_ready", 1'b0, tx_ready);
        cmp_bit("xcoded_valid", 1'b0, xcoded_valid);
        sys_rst = 1'b0;
        for (int k = 42; k < 46; k++) put(8'h00, dv(k));
        want4(dblk(42), dblk(43), dblk(44), dblk(45));
        step(20);
        cmp_bit("extra_block", 1'b0, got.size() != 0);
        $display("test mid_reset done");
        end_sim();
    end
endmodule

`default_nettype wire
